// ==== core/mps_low_timer.sv ====
`timescale 1ns/1ps
module mps_low_timer
  import mps_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             line_low,
  output logic [CNT_W-1:0]      low_cycles,
  output logic                  released
);
  logic line_low_reg;

  // Saturating count so a held line never wraps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cycles <= '0;
    end else if (!line_low) begin
      low_cycles <= '0;
    end else if (low_cycles != {CNT_W{1'b1}}) begin
      low_cycles <= low_cycles + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_low_reg <= 1'b0;
    end else begin
      line_low_reg <= line_low;
    end
  end

  assign released = line_low_reg && !line_low;
endmodule

// ==== core/mps_pkg.sv ====
package mps_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  // Key press and reset pulse lengths, in ms
  localparam int unsigned ON_PRESS_MS     = 500;
  localparam int unsigned OFF_PRESS_MS    = 650;
  localparam int unsigned RST_MIN_MS      = 150;
  localparam int unsigned RST_MAX_MS      = 460;
  // Internal sequencing lengths, in ms, and the counter width in bits
  localparam int unsigned BOOT_MS         = 10;
  localparam int unsigned SHUT_MS         = 10;
  localparam int unsigned CNT_W           = 24;
  localparam logic [CNT_W-1:0] ON_PRESS_CYC  = CNT_W'(ON_PRESS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] OFF_PRESS_CYC = CNT_W'(OFF_PRESS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_MIN_CYC   = CNT_W'(RST_MIN_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_MAX_CYC   = CNT_W'(RST_MAX_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] BOOT_CYC      = CNT_W'(BOOT_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] SHUT_CYC      = CNT_W'(SHUT_MS * CYC_PER_MS);
  typedef enum logic [2:0] {
    MPS_OFF, MPS_BOOT, MPS_RUN, MPS_SHUT_WAIT, MPS_SHUT
  } mps_state_e;
endpackage

// ==== core/mps_sequencer.sv ====
`timescale 1ns/1ps
// What this block and its host must do
// R01: Host holds the power key line low at least 500 ms to start a powered-down module.
// R02: Host releases the power key line only after the status output has gone high.
// R03: The status output is high while the module is powered on and operating.
// R04: Host waits for a stable supply, about 30 ms, before pressing the power key line.
// R05: A power key line held low permanently powers the module on and disables key shutdown.
// R06: A key press of at least 650 ms while running starts power-off only after release.
// R07: The software power-down command shuts down exactly like a key shutdown.
// R08: After a software power-down, a low power key line restarts the module once shutdown ends.
// R09: Host cuts the supply only after a completed shutdown.
// R10: A reset line pulse of 150 to 460 ms makes the module reset.
// R11: Host uses the reset line only as a fallback after other shutdowns fail.
// R12: When powered down, internal supplies are cut and software is held inactive.
// R13: Host times pulses in ms and flags a failure if the status never rises.
module mps_sequencer
  import mps_pkg::*;
#(
  // Clock cycles in one millisecond; a smaller value only shortens runs
  parameter int unsigned MS_CYC = CYC_PER_MS
)
(
  input  wire logic MCLK,
  input  wire logic NRST,
  input  wire logic POWER_KEY_LINE_N,
  input  wire logic RESET_LINE_N,
  input  wire logic SOFTWARE_POWER_DOWN_COMMAND,
  output logic      STATUS,
  output logic      SUPPLY_EN,
  output logic      CORE_RESET_N,
  output logic      SHUTDOWN_DONE
);
  mps_state_e       state_reg;
  mps_state_e       state_next;
  logic [CNT_W-1:0] seq_cnt_reg;
  logic [CNT_W-1:0] key_cycles;
  logic [CNT_W-1:0] rst_cycles;
  logic             key_released;
  logic             rst_released;
  logic             off_armed_reg;
  logic             rst_pulse_ok;
  logic             seq_done;
  logic             key_fresh_reg;

  // Millisecond figure to clock cycles, cut to the counter width
  function automatic logic [CNT_W-1:0] ms_to_cyc(input int unsigned ms);
    ms_to_cyc = CNT_W'(ms * MS_CYC);
  endfunction

  // Output levels per state
  function automatic logic status_of(input mps_state_e s);
    status_of = (s == MPS_RUN);
  endfunction

  function automatic logic supply_of(input mps_state_e s);
    supply_of = (s != MPS_OFF);
  endfunction

  // Software runs in RUN and is let finish its own shutdown in SHUT
  function automatic logic core_run_of(input mps_state_e s);
    core_run_of = (s == MPS_RUN) || (s == MPS_SHUT);
  endfunction

  function automatic logic done_of(input mps_state_e s);
    done_of = (s == MPS_OFF);
  endfunction

  localparam logic [CNT_W-1:0] on_cyc   = ms_to_cyc(ON_PRESS_MS);
  localparam logic [CNT_W-1:0] off_cyc  = ms_to_cyc(OFF_PRESS_MS);
  localparam logic [CNT_W-1:0] rst_min  = ms_to_cyc(RST_MIN_MS);
  localparam logic [CNT_W-1:0] rst_max  = ms_to_cyc(RST_MAX_MS);
  localparam logic [CNT_W-1:0] boot_cyc = ms_to_cyc(BOOT_MS);
  localparam logic [CNT_W-1:0] shut_cyc = ms_to_cyc(SHUT_MS);

  mps_low_timer u_key_timer (
    .clk        (MCLK),
    .nrst       (NRST),
    .line_low   (!POWER_KEY_LINE_N),
    .low_cycles (key_cycles),
    .released   (key_released)
  );

  mps_low_timer u_rst_timer (
    .clk        (MCLK),
    .nrst       (NRST),
    .line_low   (!RESET_LINE_N),
    .low_cycles (rst_cycles),
    .released   (rst_released)
  );

  // Pulse length seen on the release cycle is the count of the cycle before
  // A pulse outside the window is dropped silently; nothing is flagged
  assign rst_pulse_ok = rst_released
                        && (rst_cycles >= rst_min)
                        && (rst_cycles <= rst_max); // R10
  assign seq_done     = (seq_cnt_reg == '0);

  // A press only counts for power-off if it began while running, so a key
  // strapped low through boot can never shut the module down
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      key_fresh_reg <= 1'b0;
    end else if (state_reg != MPS_RUN) begin
      key_fresh_reg <= 1'b0;
    end else if (POWER_KEY_LINE_N) begin
      key_fresh_reg <= 1'b1; // R05
    end
  end

  // Press armed once the key has been low long enough; acted on at release
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      off_armed_reg <= 1'b0;
    end else if (state_reg != MPS_RUN) begin
      off_armed_reg <= 1'b0;
    end else if (key_released) begin
      off_armed_reg <= 1'b0;
    end else if (key_fresh_reg && (key_cycles >= off_cyc - CNT_W'(1))) begin
      off_armed_reg <= 1'b1; // R06
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MPS_OFF: begin
        // Key held from power-up counts too, so a strapped key boots
        if (key_cycles >= on_cyc - CNT_W'(1)) begin
          state_next = MPS_BOOT; // R01 R05
        end
      end
      MPS_BOOT: begin
        if (seq_done) begin
          state_next = MPS_RUN;
        end
      end
      MPS_RUN: begin
        // Reset wins over command and key
        if (rst_pulse_ok) begin
          state_next = MPS_BOOT; // R10
        end else if (SOFTWARE_POWER_DOWN_COMMAND) begin
          state_next = MPS_SHUT; // R07
        end else if (off_armed_reg && key_released) begin
          state_next = MPS_SHUT; // R06
        end
      end
      // Spare code, never entered; falls into SHUT
      MPS_SHUT_WAIT: begin
        state_next = MPS_SHUT;
      end
      MPS_SHUT: begin
        if (seq_done) begin
          // Key still low after shutdown brings the module straight back
          state_next = POWER_KEY_LINE_N ? MPS_OFF : MPS_BOOT; // R08
        end
      end
      // Undefined codes 5 to 7 fall back to off
      default: begin
        state_next = MPS_OFF;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= MPS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      seq_cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      // Reload one short: the entry edge counts as a cycle
      if (state_next == MPS_BOOT) begin
        seq_cnt_reg <= boot_cyc - CNT_W'(1);
      end else if (state_next == MPS_SHUT) begin
        seq_cnt_reg <= shut_cyc - CNT_W'(1);
      end else begin
        seq_cnt_reg <= '0;
      end
    end else if (!seq_done) begin
      seq_cnt_reg <= seq_cnt_reg - CNT_W'(1);
    end
  end

  // Outputs registered from the next state so they line up with it
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      STATUS <= 1'b0;
    end else begin
      STATUS <= status_of(state_next); // R03
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      SUPPLY_EN <= 1'b0;
    end else begin
      SUPPLY_EN <= supply_of(state_next); // R12
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CORE_RESET_N <= 1'b0;
    end else begin
      CORE_RESET_N <= core_run_of(state_next); // R12
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      SHUTDOWN_DONE <= 1'b0;
    end else begin
      SHUTDOWN_DONE <= done_of(state_next);
    end
  end
endmodule

// ==== tb/mps_host_model.sv ====
`timescale 1ns/1ps
module mps_host_model
  import mps_pkg::*;
#(
  parameter int unsigned MS_CYC = CYC_PER_MS
)
(
  input  wire logic MCLK,
  input  wire logic STATUS,
  output logic      key_n,
  output logic      rst_n
);
  logic ready;
  initial begin
    key_n = 1'b1;
    rst_n = 1'b1;
    ready = 1'b0;
    repeat (30 * MS_CYC) @(negedge MCLK);
    ready = 1'b1;
  end
  task automatic set_key(input logic level);
    key_n = level;
  endtask
  task automatic press(input int n);
    wait (ready);
    @(negedge MCLK) key_n = 1'b0;
    repeat (n) @(negedge MCLK);
    key_n = 1'b1;
  endtask
  // Bounded so a dead module is flagged, not waited on forever
  task automatic power_on(output int n);
    wait (ready);
    n = 0;
    @(negedge MCLK) key_n = 1'b0;
    while (STATUS !== 1'b1 && n < int'(2 * ON_PRESS_MS * MS_CYC)) begin
      @(negedge MCLK);
      n++;
    end
    key_n = 1'b1;
  endtask
  task automatic pulse_reset(input int n);
    @(negedge MCLK) rst_n = 1'b0;
    repeat (n) @(negedge MCLK);
    rst_n = 1'b1;
  endtask
endmodule

// ==== tb/mps_sequencer_bench.sv ====
`timescale 1ns/1ps
module mps_sequencer_bench;
  import mps_pkg::*;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd = 1'b0;
  wire        key_n, rst_n, status, supply_en, core_reset_n, shutdown_done;
  wire  [3:0] outs = {status, supply_en, core_reset_n, shutdown_done};
  int         miscompares = 0;
  int         num_checks = 0;
  int         seed = 23175;
  int         n;
  // Shortened millisecond keeps the run small; all lengths scale with it
  localparam int bench_ms = 20;
  localparam int on_cyc   = ON_PRESS_MS * bench_ms;
  localparam int off_cyc  = OFF_PRESS_MS * bench_ms;
  localparam int rst_min  = RST_MIN_MS * bench_ms;
  localparam int boot_cyc = BOOT_MS * bench_ms;
  localparam int shut_cyc = SHUT_MS * bench_ms;
  always #25 mclk = ~mclk;
  mps_host_model #(.MS_CYC(bench_ms)) host (.MCLK(mclk), .STATUS(status), .key_n(key_n),
    .rst_n(rst_n));
  mps_sequencer #(.MS_CYC(bench_ms)) dut (.MCLK(mclk), .NRST(nrst),
    .POWER_KEY_LINE_N(key_n), .RESET_LINE_N(rst_n),
    .SOFTWARE_POWER_DOWN_COMMAND(cmd), .STATUS(status), .SUPPLY_EN(supply_en),
    .CORE_RESET_N(core_reset_n), .SHUTDOWN_DONE(shutdown_done));
  // Modes: 0 off, 1 boot, 2 run, 3 shutting down
  function automatic logic [3:0] rails(input int m);
    case (m)
      0: rails = 4'h1;
      1: rails = 4'h4;
      2: rails = 4'he;
      default: rails = 4'h6;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    nrst = 1'b1;
    cyc(1);
    chk(outs, rails(0));
    host.press(100 + int'($random(seed) & 32'h00001fff));
    cyc(4);
    chk(outs, rails(0));
    cmd = 1'b1;
    cyc(2);
    cmd = 1'b0;
    chk(outs, rails(0));
    host.power_on(n);
    chk(status, 1'b1);
    chk(n, on_cyc + boot_cyc);
    chk(outs, rails(2));
    host.pulse_reset(100 + int'($random(seed) & 32'h000003ff));
    cyc(4);
    chk(outs, rails(2));
    host.pulse_reset(rst_min + 100 + int'($random(seed) & 32'h00000fff));
    cyc(2);
    chk(outs, rails(1));
    cyc(boot_cyc + 4);
    chk(outs, rails(2));
    host.set_key(1'b0);
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    chk(outs, rails(3));
    cyc(shut_cyc + 4);
    chk(outs, rails(1));
    cyc(boot_cyc);
    chk(outs, rails(2));
    host.set_key(1'b1);
    cyc(4);
    chk(outs, rails(2));
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    chk(outs, rails(3));
    cyc(shut_cyc + 4);
    chk(outs, rails(0));
    host.power_on(n);
    chk(status, 1'b1);
    cyc(4);
    host.set_key(1'b0);
    cyc(off_cyc + int'($random(seed) & 32'h000003ff));
    chk(outs, rails(2));
    host.set_key(1'b1);
    cyc(1);
    chk(outs, rails(3));
    cyc(shut_cyc + 4);
    chk(outs, rails(0));
    tally_and_finish();
  end
endmodule

// ==== tb/mps_sequencer_properties.sv ====
`timescale 1ns/1ps
module mps_sequencer_checker (
  input logic MCLK,
  input logic NRST,
  input logic POWER_KEY_LINE_N,
  input logic RESET_LINE_N,
  input logic SOFTWARE_POWER_DOWN_COMMAND,
  input logic STATUS,
  input logic SUPPLY_EN,
  input logic CORE_RESET_N,
  input logic SHUTDOWN_DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  live_powered_a: assert property (STATUS |-> SUPPLY_EN && CORE_RESET_N && !SHUTDOWN_DONE)
    else $error("run without power");
  off_dark_a: assert property (SHUTDOWN_DONE |-> !SUPPLY_EN && !STATUS)
    else $error("powered while off");
  cmd_stops_a: assert property (STATUS && SOFTWARE_POWER_DOWN_COMMAND |=> !STATUS)
    else $error("command ignored");
  key_no_early_a: assert property (STATUS && !POWER_KEY_LINE_N && !SOFTWARE_POWER_DOWN_COMMAND
    && !(RESET_LINE_N && !$past(RESET_LINE_N)) |=> STATUS) else $error("off before release");
  rst_no_early_a: assert property (STATUS && !RESET_LINE_N && !SOFTWARE_POWER_DOWN_COMMAND
    && POWER_KEY_LINE_N && $past(POWER_KEY_LINE_N) |=> STATUS) else $error("reset early");
  shut_rail_a: assert property ($fell(STATUS) |-> SUPPLY_EN [*8])
    else $error("rail dropped at once");
  boot_first_a: assert property ($rose(STATUS) |-> $past(SUPPLY_EN, 8) && !$past(CORE_RESET_N))
    else $error("run without boot");
  done_rail_a: assert property ($rose(SHUTDOWN_DONE) && $past(NRST, 2) |-> $fell(SUPPLY_EN))
    else $error("done without cut");
endmodule
bind mps_sequencer mps_sequencer_checker chk (.MCLK(MCLK), .NRST(NRST),
  .POWER_KEY_LINE_N(POWER_KEY_LINE_N), .RESET_LINE_N(RESET_LINE_N),
  .SOFTWARE_POWER_DOWN_COMMAND(SOFTWARE_POWER_DOWN_COMMAND), .STATUS(STATUS),
  .SUPPLY_EN(SUPPLY_EN), .CORE_RESET_N(CORE_RESET_N), .SHUTDOWN_DONE(SHUTDOWN_DONE));
